// ---- core/rcr_top.sv ----
// Regulator control register bank: register port, decode and per-regulator sets
`default_nettype none
`include "rcr_params.svh"

module rcr_top (
    input wire logic I_CLK_SYS,
    input wire logic I_NRST,
    input wire rcr_pkg::rcr_byte_type I_REG_ADDR,
    input wire logic I_REG_WR,
    input wire logic I_REG_RD,
    input wire rcr_pkg::rcr_byte_type I_REG_WDATA,
    input wire logic I_VOLTAGE_BANK_SELECT_PIN,
    input wire logic [5:0] I_PWR_GOOD,
    input wire logic [5:0] I_FAULT,
    output rcr_pkg::rcr_byte_type O_REG_RDATA,
    output logic O_REG_RVALID,
    output logic [3:0] O_BUCK_EN,
    output logic [3:0] O_BUCK_PHASE,
    output logic [17:0] O_BUCK_VCODE,
    output logic [1:0] O_LDO_EN,
    output logic [1:0] O_LDO_DISCHARGE,
    output logic [11:0] O_LDO_VCODE,
    output logic O_FAULT_IRQ
);
    import rcr_pkg::*;

    localparam int NB = 3;
    localparam int NL = 2;
    localparam rcr_byte_type BUCK_PRI[NB] = '{`RCR_ADDR_BUCK2_PRI, `RCR_ADDR_BUCK3_PRI,
                                              `RCR_ADDR_BUCK4_PRI};
    localparam rcr_byte_type BUCK_SEC[NB] = '{`RCR_ADDR_BUCK2_SEC, `RCR_ADDR_BUCK3_SEC,
                                              `RCR_ADDR_BUCK4_SEC};
    localparam rcr_byte_type BUCK_CTL[NB] = '{`RCR_ADDR_BUCK2_CTL, `RCR_ADDR_BUCK3_CTL,
                                              `RCR_ADDR_BUCK4_CTL};
    localparam rcr_byte_type LDO_VOLT[NL] = '{`RCR_ADDR_LDO5_VOLT, `RCR_ADDR_LDO6_VOLT};
    localparam rcr_byte_type LDO_CTL[NL] = '{`RCR_ADDR_LDO5_CTL, `RCR_ADDR_LDO6_CTL};

    // First buck: control register only
    logic b1_on_q;
    logic b1_phase_q;
    logic b1_irq_en_q;
    logic b1_irq_q;
    logic hit_b1;
    rcr_byte_type b1_rd;

    rcr_byte_type buck_rd[NB];
    rcr_byte_type ldo_rd[NL];
    logic [NB-1:0] buck_irq;
    logic [NL-1:0] ldo_irq;
    logic [NB-1:0] buck_hit;
    logic [NL-1:0] ldo_hit;
    rcr_byte_type rd_mux;
    logic any_hit;
    logic irq_d;

    assign hit_b1 = (I_REG_ADDR == `RCR_ADDR_BUCK1_CTL);
    assign b1_rd = {8{hit_b1}} & rcr_ctl_byte(b1_on_q, b1_phase_q, b1_irq_en_q,
                                             I_PWR_GOOD[0]);

    always_ff @(posedge I_CLK_SYS) begin
        if (!I_NRST) begin
            b1_on_q <= `RCR_RST_BIT;
            b1_phase_q <= `RCR_RST_BIT;
            b1_irq_en_q <= `RCR_RST_BIT;
            b1_irq_q <= `RCR_RST_BIT;
        end else begin
            if (I_REG_WR && hit_b1) begin
                b1_on_q <= I_REG_WDATA[`RCR_BIT_ON];
                b1_phase_q <= I_REG_WDATA[`RCR_BIT_MODE];
                b1_irq_en_q <= I_REG_WDATA[`RCR_BIT_IRQ_EN];
            end
            b1_irq_q <= I_FAULT[0] & b1_irq_en_q;
        end
    end

    assign O_BUCK_EN[0] = b1_on_q;
    assign O_BUCK_PHASE[0] = b1_phase_q;

    // Dual-setpoint bucks
    for (genvar i = 0; i < NB; i++) begin : g_buck
        logic hp;
        logic hs;
        logic hc;
        rcr_byte_type pri_rd;
        rcr_byte_type sec_rd;
        rcr_byte_type ctl_rd;
        assign hp = (I_REG_ADDR == BUCK_PRI[i]);
        assign hs = (I_REG_ADDR == BUCK_SEC[i]);
        assign hc = (I_REG_ADDR == BUCK_CTL[i]);
        assign buck_hit[i] = hp | hs | hc;
        assign buck_rd[i] = ({8{hp}} & pri_rd) | ({8{hs}} & sec_rd) | ({8{hc}} & ctl_rd);
        rcr_buck_regs u_buck (
            .i_clk(I_CLK_SYS),
            .i_nrst(I_NRST),
            .i_wr_pri(I_REG_WR & hp),
            .i_wr_sec(I_REG_WR & hs),
            .i_wr_ctl(I_REG_WR & hc),
            .i_wdata(I_REG_WDATA),
            .i_bank_sel(I_VOLTAGE_BANK_SELECT_PIN),
            .i_pwr_good(I_PWR_GOOD[i+1]),
            .i_fault(I_FAULT[i+1]),
            .o_pri_rd(pri_rd),
            .o_sec_rd(sec_rd),
            .o_ctl_rd(ctl_rd),
            .o_enable(O_BUCK_EN[i+1]),
            .o_phase(O_BUCK_PHASE[i+1]),
            .o_irq(buck_irq[i]),
            .o_code(O_BUCK_VCODE[6*i +: 6])
        );
    end

    // Single-setpoint LDOs
    for (genvar j = 0; j < NL; j++) begin : g_ldo
        logic hv;
        logic hc;
        rcr_byte_type volt_rd;
        rcr_byte_type ctl_rd;
        assign hv = (I_REG_ADDR == LDO_VOLT[j]);
        assign hc = (I_REG_ADDR == LDO_CTL[j]);
        assign ldo_hit[j] = hv | hc;
        assign ldo_rd[j] = ({8{hv}} & volt_rd) | ({8{hc}} & ctl_rd);
        rcr_ldo_regs u_ldo (
            .i_clk(I_CLK_SYS),
            .i_nrst(I_NRST),
            .i_wr_volt(I_REG_WR & hv),
            .i_wr_ctl(I_REG_WR & hc),
            .i_wdata(I_REG_WDATA),
            .i_pwr_good(I_PWR_GOOD[j+4]),
            .i_fault(I_FAULT[j+4]),
            .o_volt_rd(volt_rd),
            .o_ctl_rd(ctl_rd),
            .o_enable(O_LDO_EN[j]),
            .o_discharge(O_LDO_DISCHARGE[j]),
            .o_irq(ldo_irq[j]),
            .o_code(O_LDO_VCODE[6*j +: 6])
        );
    end

    // Read selection, unmapped offsets read zero
    assign rd_mux = b1_rd | buck_rd[0] | buck_rd[1] | buck_rd[2] | ldo_rd[0] | ldo_rd[1];
    assign any_hit = hit_b1 | (|buck_hit) | (|ldo_hit);
    assign irq_d = b1_irq_q | (|buck_irq) | (|ldo_irq);

    always_ff @(posedge I_CLK_SYS) begin
        if (!I_NRST) begin
            O_REG_RDATA <= `RCR_RST_BYTE;
            O_REG_RVALID <= `RCR_RST_BIT;
            O_FAULT_IRQ <= `RCR_RST_BIT;
        end else begin
            O_REG_RVALID <= I_REG_RD;
            if (I_REG_RD) begin
                O_REG_RDATA <= any_hit ? rd_mux : `RCR_RST_BYTE;
            end
            O_FAULT_IRQ <= irq_d;
        end
    end
endmodule

`default_nettype wire

// ---- inc/rcr_params.svh ----
// Offsets, field positions and reset values of the regulator control register bank
`ifndef RCR_PARAMS_SVH
`define RCR_PARAMS_SVH

// Register offsets
`define RCR_ADDR_BUCK1_CTL 8'h12
`define RCR_ADDR_BUCK2_PRI 8'h20
`define RCR_ADDR_BUCK2_SEC 8'h21
`define RCR_ADDR_BUCK2_CTL 8'h22
`define RCR_ADDR_BUCK3_PRI 8'h30
`define RCR_ADDR_BUCK3_SEC 8'h31
`define RCR_ADDR_BUCK3_CTL 8'h32
`define RCR_ADDR_BUCK4_PRI 8'h40
`define RCR_ADDR_BUCK4_SEC 8'h41
`define RCR_ADDR_BUCK4_CTL 8'h42
`define RCR_ADDR_LDO5_VOLT 8'h50
`define RCR_ADDR_LDO5_CTL 8'h51
`define RCR_ADDR_LDO6_VOLT 8'h58
`define RCR_ADDR_LDO6_CTL 8'h59

// Field positions
`define RCR_BIT_ON 7
`define RCR_BIT_MODE 2
`define RCR_BIT_IRQ_EN 1
`define RCR_BIT_OK 0
`define RCR_CODE_MSB 5

// Reset values
`define RCR_RST_CODE 6'h00
`define RCR_RST_BIT 1'b0
`define RCR_RST_BYTE 8'h00

`endif

// ---- inc/rcr_pkg.sv ----
// Types and packing functions of the regulator control register bank
`default_nettype none
`include "rcr_params.svh"

package rcr_pkg;
    typedef logic [7:0] rcr_byte_type;
    typedef logic [`RCR_CODE_MSB:0] rcr_code_type;

    // Control register image, reserved bits 6..3 forced to zero
    function automatic rcr_byte_type rcr_ctl_byte(input logic on, input logic mode,
                                                  input logic irq_en, input logic ok);
        rcr_byte_type b;
        b = `RCR_RST_BYTE;
        b[`RCR_BIT_ON] = on;
        b[`RCR_BIT_MODE] = mode;
        b[`RCR_BIT_IRQ_EN] = irq_en;
        b[`RCR_BIT_OK] = ok;
        return b;
    endfunction

    // Voltage register image, reserved bits 7..6 forced to zero
    function automatic rcr_byte_type rcr_code_byte(input rcr_code_type code);
        rcr_byte_type b;
        b = `RCR_RST_BYTE;
        b[`RCR_CODE_MSB:0] = code;
        return b;
    endfunction
endpackage

`default_nettype wire

// ---- core/rcr_buck_regs.sv ----
// Dual-setpoint switching regulator register set
`default_nettype none
`include "rcr_params.svh"

module rcr_buck_regs (
    input wire logic i_clk,
    input wire logic i_nrst,
    input wire logic i_wr_pri,
    input wire logic i_wr_sec,
    input wire logic i_wr_ctl,
    input wire rcr_pkg::rcr_byte_type i_wdata,
    input wire logic i_bank_sel,
    input wire logic i_pwr_good,
    input wire logic i_fault,
    output rcr_pkg::rcr_byte_type o_pri_rd,
    output rcr_pkg::rcr_byte_type o_sec_rd,
    output rcr_pkg::rcr_byte_type o_ctl_rd,
    output logic o_enable,
    output logic o_phase,
    output logic o_irq,
    output rcr_pkg::rcr_code_type o_code
);
    import rcr_pkg::*;

    rcr_code_type pri_q;
    rcr_code_type sec_q;
    logic irq_en_q;
    rcr_code_type code_d;
    logic irq_d;

    // Pin picks the active setpoint
    assign code_d = i_bank_sel ? sec_q : pri_q;
    assign irq_d = i_fault & irq_en_q;

    assign o_pri_rd = rcr_code_byte(pri_q);
    assign o_sec_rd = rcr_code_byte(sec_q);
    assign o_ctl_rd = rcr_ctl_byte(o_enable, o_phase, irq_en_q, i_pwr_good);

    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            pri_q <= `RCR_RST_CODE;
            sec_q <= `RCR_RST_CODE;
            o_enable <= `RCR_RST_BIT;
            o_phase <= `RCR_RST_BIT;
            irq_en_q <= `RCR_RST_BIT;
            o_code <= `RCR_RST_CODE;
            o_irq <= `RCR_RST_BIT;
        end else begin
            if (i_wr_pri) begin
                pri_q <= i_wdata[`RCR_CODE_MSB:0];
            end
            if (i_wr_sec) begin
                sec_q <= i_wdata[`RCR_CODE_MSB:0];
            end
            if (i_wr_ctl) begin
                o_enable <= i_wdata[`RCR_BIT_ON];
                o_phase <= i_wdata[`RCR_BIT_MODE];
                irq_en_q <= i_wdata[`RCR_BIT_IRQ_EN];
            end
            o_code <= code_d;
            o_irq <= irq_d;
        end
    end
endmodule

`default_nettype wire

// ---- core/rcr_ldo_regs.sv ----
// Single-setpoint low-dropout regulator register set
`default_nettype none
`include "rcr_params.svh"

module rcr_ldo_regs (
    input wire logic i_clk,
    input wire logic i_nrst,
    input wire logic i_wr_volt,
    input wire logic i_wr_ctl,
    input wire rcr_pkg::rcr_byte_type i_wdata,
    input wire logic i_pwr_good,
    input wire logic i_fault,
    output rcr_pkg::rcr_byte_type o_volt_rd,
    output rcr_pkg::rcr_byte_type o_ctl_rd,
    output logic o_enable,
    output logic o_discharge,
    output logic o_irq,
    output rcr_pkg::rcr_code_type o_code
);
    import rcr_pkg::*;

    logic dchg_en_q;
    logic irq_en_q;
    logic on_d;
    logic dchg_en_d;

    assign on_d = i_wr_ctl ? i_wdata[`RCR_BIT_ON] : o_enable;
    assign dchg_en_d = i_wr_ctl ? i_wdata[`RCR_BIT_MODE] : dchg_en_q;

    assign o_volt_rd = rcr_code_byte(o_code);
    assign o_ctl_rd = rcr_ctl_byte(o_enable, dchg_en_q, irq_en_q, i_pwr_good);

    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            o_code <= `RCR_RST_CODE;
            o_enable <= `RCR_RST_BIT;
            dchg_en_q <= `RCR_RST_BIT;
            irq_en_q <= `RCR_RST_BIT;
            o_discharge <= `RCR_RST_BIT;
            o_irq <= `RCR_RST_BIT;
        end else begin
            if (i_wr_volt) begin
                o_code <= i_wdata[`RCR_CODE_MSB:0];
            end
            if (i_wr_ctl) begin
                irq_en_q <= i_wdata[`RCR_BIT_IRQ_EN];
            end
            o_enable <= on_d;
            dchg_en_q <= dchg_en_d;
            o_discharge <= dchg_en_d & ~on_d;
            o_irq <= i_fault & irq_en_q;
        end
    end
endmodule

`default_nettype wire

// ---- tb/rcr_top_sva.sv ----
// Assertion checker for the regulator control register bank
`default_nettype none
module rcr_top_sva (
    input wire logic I_CLK_SYS,
    input wire logic I_NRST,
    input wire rcr_pkg::rcr_byte_type I_REG_ADDR,
    input wire logic I_REG_WR,
    input wire logic I_REG_RD,
    input wire rcr_pkg::rcr_byte_type I_REG_WDATA,
    input wire logic I_VOLTAGE_BANK_SELECT_PIN,
    input wire logic [5:0] I_PWR_GOOD,
    input wire logic [5:0] I_FAULT,
    input wire rcr_pkg::rcr_byte_type O_REG_RDATA,
    input wire logic O_REG_RVALID,
    input wire logic [3:0] O_BUCK_EN,
    input wire logic [3:0] O_BUCK_PHASE,
    input wire logic [17:0] O_BUCK_VCODE,
    input wire logic [1:0] O_LDO_EN,
    input wire logic [1:0] O_LDO_DISCHARGE,
    input wire logic [11:0] O_LDO_VCODE,
    input wire logic O_FAULT_IRQ
);
    timeunit 1ns;
    timeprecision 100ps;
    import rcr_pkg::*;
    default clocking cb @(posedge I_CLK_SYS); endclocking
    default disable iff (!I_NRST);
    property p_pri;
        I_REG_WR && I_REG_ADDR == 8'h20 && !I_VOLTAGE_BANK_SELECT_PIN ##1
        !I_VOLTAGE_BANK_SELECT_PIN |=> O_BUCK_VCODE[5:0] == $past(I_REG_WDATA[5:0], 2);
    endproperty
    a_pri: assert property (p_pri) else $error("primary code");
    property p_sec;
        I_REG_WR && I_REG_ADDR == 8'h31 && I_VOLTAGE_BANK_SELECT_PIN ##1
        I_VOLTAGE_BANK_SELECT_PIN |=> O_BUCK_VCODE[11:6] == $past(I_REG_WDATA[5:0], 2);
    endproperty
    a_sec: assert property (p_sec) else $error("secondary code");
    property p_on;
        I_REG_WR && I_REG_ADDR == 8'h12 |=> O_BUCK_EN[0] == $past(I_REG_WDATA[7]);
    endproperty
    a_on: assert property (p_on) else $error("enable");
    property p_ldo_on;
        I_REG_WR && I_REG_ADDR == 8'h51 |=> O_LDO_EN[0] == $past(I_REG_WDATA[7]);
    endproperty
    a_ldo_on: assert property (p_ldo_on) else $error("ldo enable");
    property p_ph;
        I_REG_WR && I_REG_ADDR == 8'h42 |=> O_BUCK_PHASE[3] == $past(I_REG_WDATA[2]);
    endproperty
    a_ph: assert property (p_ph) else $error("phase");
    property p_dis;
        I_REG_WR && I_REG_ADDR == 8'h59 |=>
        O_LDO_DISCHARGE[1] == ($past(I_REG_WDATA[2]) && !$past(I_REG_WDATA[7]));
    endproperty
    a_dis: assert property (p_dis) else $error("discharge");
    property p_pg;
        I_REG_RD && I_REG_ADDR == 8'h22 |=> O_REG_RVALID &&
        O_REG_RDATA[0] == $past(I_PWR_GOOD[1]) && O_REG_RDATA[6:3] == 4'h0;
    endproperty
    a_pg: assert property (p_pg) else $error("power good");
    property p_rsv;
        I_REG_RD && I_REG_ADDR == 8'h50 |=> O_REG_RVALID && O_REG_RDATA[7:6] == 2'h0;
    endproperty
    a_rsv: assert property (p_rsv) else $error("reserved");
    property p_ldo;
        $changed(I_VOLTAGE_BANK_SELECT_PIN) && !I_REG_WR && !$past(I_REG_WR) |=>
        $stable(O_LDO_VCODE);
    endproperty
    a_ldo: assert property (p_ldo) else $error("ldo code moved");
    property p_irq;
        $past(I_FAULT) == 6'h00 |=> !O_FAULT_IRQ;
    endproperty
    a_irq: assert property (p_irq) else $error("spurious irq");
    c_irq: cover property (O_FAULT_IRQ);
    c_sel: cover property ($rose(I_VOLTAGE_BANK_SELECT_PIN));
    c_rd: cover property (O_REG_RVALID);
endmodule
`default_nettype wire

// ---- tb/rcr_host_model.sv ----
// Host model driving the register port
`default_nettype none
module rcr_host_model (
    input wire logic i_clk,
    input wire rcr_pkg::rcr_byte_type i_rdata,
    input wire logic i_rvalid,
    output rcr_pkg::rcr_byte_type o_addr = 8'h00,
    output logic o_wr = 1'b0,
    output logic o_rd = 1'b0,
    output rcr_pkg::rcr_byte_type o_wdata = 8'h00
);
    timeunit 1ns;
    timeprecision 100ps;
    import rcr_pkg::*;
    task automatic wr(input rcr_byte_type a, input rcr_byte_type d);
        @(posedge i_clk);
        o_addr <= a;
        o_wdata <= d;
        o_wr <= 1'b1;
        @(posedge i_clk);
        o_wr <= 1'b0;
        o_addr <= ~a;
        o_wdata <= ~d;
    endtask
    task automatic rd(input rcr_byte_type a, output rcr_byte_type d, output logic ok);
        @(posedge i_clk);
        o_addr <= a;
        o_rd <= 1'b1;
        @(posedge i_clk);
        o_rd <= 1'b0;
        o_addr <= ~a;
        ok = 1'b0;
        d = 8'h00;
        for (int n = 0; n < 4 && !ok; n++) begin
            #1;
            ok = (i_rvalid === 1'b1);
            d = i_rdata;
            if (!ok) begin
                @(posedge i_clk);
            end
        end
    endtask
endmodule
`default_nettype wire

// ---- tb/rcr_tb_top.sv ----
// Self-checking bench for the regulator control register bank
`default_nettype none
module rcr_tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    import rcr_pkg::*;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic sel = 1'b0;
    logic [5:0] pg = 6'h00;
    logic [5:0] flt = 6'h00;
    rcr_byte_type addr, wdata, rdata;
    logic wr, rd, rvalid, irq;
    logic [3:0] b_en, b_ph;
    logic [17:0] b_code;
    logic [1:0] l_en, l_dchg;
    logic [11:0] l_code;
    int fails = 0;
    int cmp_count = 0;
    rcr_byte_type va[8] = '{8'h20, 8'h21, 8'h30, 8'h31, 8'h40, 8'h41, 8'h50, 8'h58};
    rcr_byte_type ca[6] = '{8'h12, 8'h22, 8'h32, 8'h42, 8'h51, 8'h59};
    always #2.5 clk = ~clk;
    rcr_host_model i_rcr_host_model (.i_clk(clk), .i_rdata(rdata), .i_rvalid(rvalid),
        .o_addr(addr), .o_wr(wr), .o_rd(rd), .o_wdata(wdata));
    rcr_top i_rcr_top (.I_CLK_SYS(clk), .I_NRST(nrst), .I_REG_ADDR(addr), .I_REG_WR(wr),
        .I_REG_RD(rd), .I_REG_WDATA(wdata), .I_VOLTAGE_BANK_SELECT_PIN(sel),
        .I_PWR_GOOD(pg), .I_FAULT(flt), .O_REG_RDATA(rdata), .O_REG_RVALID(rvalid),
        .O_BUCK_EN(b_en), .O_BUCK_PHASE(b_ph), .O_BUCK_VCODE(b_code), .O_LDO_EN(l_en),
        .O_LDO_DISCHARGE(l_dchg), .O_LDO_VCODE(l_code), .O_FAULT_IRQ(irq));
    task automatic conclude();
        if (fails == 0 && cmp_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [17:0] seen, input logic [17:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            fails++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic rchk(input rcr_byte_type a, input rcr_byte_type exp);
        rcr_byte_type d;
        logic ok;
        i_rcr_host_model.rd(a, d, ok);
        if (ok !== 1'b1) begin
            fails++;
            $display("[ERR] %0t read timeout", $time);
            conclude();
        end else begin
            chk(18'(d), 18'(exp));
        end
    endtask
    initial begin
        repeat (10) @(posedge clk);
        nrst <= 1'b1;
        foreach (va[i]) rchk(va[i], 8'h00);
        foreach (ca[i]) rchk(ca[i], 8'h00);
        foreach (va[i]) begin
            @(posedge clk);
            sel <= va[i][0];
            i_rcr_host_model.wr(va[i], va[i] ^ 8'hC5);
        end
        foreach (ca[i]) i_rcr_host_model.wr(ca[i], 8'hFF);
        foreach (va[i]) rchk(va[i], (va[i] ^ 8'hC5) & 8'h3F);
        foreach (ca[i]) rchk(ca[i], 8'h86);
        chk(18'(b_en), 18'h0_000F);
        chk(18'(b_ph), 18'h0_000F);
        chk(18'(l_en), 18'h0_0003);
        chk(18'(l_dchg), 18'h0_0000);
        @(posedge clk);
        sel <= 1'b0;
        repeat (3) @(posedge clk);
        chk(b_code, {6'h05, 6'h35, 6'h25});
        chk(18'(l_code), {6'h00, 6'h1D, 6'h15});
        sel <= 1'b1;
        repeat (3) @(posedge clk);
        chk(b_code, {6'h04, 6'h34, 6'h24});
        chk(18'(l_code), {6'h00, 6'h1D, 6'h15});
        pg <= 6'h3F;
        foreach (ca[i]) rchk(ca[i], 8'h87);
        i_rcr_host_model.wr(8'h51, 8'h04);
        i_rcr_host_model.wr(8'h59, 8'h78);
        repeat (2) @(posedge clk);
        chk(18'(l_en), 18'h0_0000);
        chk(18'(l_dchg), 18'h0_0001);
        rchk(8'h59, 8'h01);
        @(posedge clk);
        flt <= 6'h30;
        repeat (3) @(posedge clk);
        chk(18'(irq), 18'h0_0000);
        flt <= 6'h01;
        repeat (3) @(posedge clk);
        chk(18'(irq), 18'h0_0001);
        i_rcr_host_model.wr(8'h12, 8'h80);
        repeat (3) @(posedge clk);
        chk(18'(irq), 18'h0_0000);
        chk(18'(b_ph), 18'h0_000E);
        i_rcr_host_model.wr(8'h10, 8'hFF);
        rchk(8'h10, 8'h00);
        @(posedge clk);
        nrst <= 1'b0;
        repeat (2) @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
        chk(18'(b_en), 18'h0_0000);
        rchk(8'h22, 8'h01);
        conclude();
    end
endmodule
bind rcr_top rcr_top_sva i_rcr_top_sva (.*);
`default_nettype wire
